// *** rtl/ltc_pkg.sv ***
// constants and types for the line transceiver control word
package ltc_pkg;

   // ****************************************
   // control word layout
   // ****************************************
   localparam int unsigned CW_W            = 8;
   localparam logic [1:0]  SEL_CTRL        = 2'h0;
   localparam logic [1:0]  SEL_DIAG        = 2'h2;
   localparam int unsigned BIT_DIAG_HOLD   = 2;
   localparam int unsigned BIT_RATE        = 3;
   localparam int unsigned BIT_SIG_BEARER  = 4;
   localparam int unsigned BIT_SCRAMBLE    = 5;
   localparam int unsigned BIT_FAST        = 6;
   localparam int unsigned BIT_HK          = 7;
   localparam logic [7:0]  DEFAULT_MASK    = 8'hF0;
   localparam logic [7:0]  DEFAULT1_WORD   = 8'h00;
   localparam logic [7:0]  DEFAULT2_WORD   = 8'h08;
   localparam logic [7:0]  CW_RESET        = 8'h00;

   // ****************************************
   // signalling bits per frame
   // ****************************************
   localparam logic [3:0]  SIG_BITS_80     = 4'h1;
   localparam logic [3:0]  SIG_BITS_160    = 4'h2;
   localparam logic [3:0]  SIG_BITS_ALL    = 4'h8;

   // ****************************************
   // mode encodings
   // ****************************************
   localparam logic [1:0]  DEFMODE_NONE    = 2'h0;
   localparam logic [1:0]  DEFMODE_1       = 2'h1;
   localparam logic [1:0]  DEFMODE_2       = 2'h2;
   localparam logic [7:0]  RST_SYNC_INIT   = 8'h00;

   // one byte from the control channel, already deserialised
   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
   } ltc_cbyte_t;

   // one data bit with its strobe
   typedef struct packed
   {
      logic valid;
      logic dat;
   } ltc_bit_t;

   // decoded control fields
   typedef struct packed
   {
      logic tx_housekeeping;
      logic fast_converge;
      logic scrambler_enable;
      logic signalling_in_bearer;
      logic line_rate_select;
      logic diag_clear_hold;
   } ltc_fields_t;

endpackage : ltc_pkg

// *** rtl/ltc_control_word.sv ***
// control word register, default modes and the logic it steers
// Behaviour
// - bits 0,1 of a byte: 00 selects control word, 0 then 1 diagnostics
// - hold bit written 0 clears diagnostics at next frame pulse; 1 keeps them only if no clear is already pending
// - bit 3 picks line rate: 0 is 80 kbit/s, 1 is 160 kbit/s
// - bearer bit set moves the whole signalling byte to first bearer slot
// - fast converge bit selects fast echo adaptation, otherwise normal speed
// - bit 7 is sent on the line as the housekeeping bit
// - bits 4 to 7 all one ignore fields; bit 3 picks the default
// - first default mode clears the whole internal word
// - second default mode sets only the rate bit, 160 kbit/s
`timescale 1ns/1ns
module ltc_control_word
#(
   parameter int unsigned  SCR_W       = 23,
   parameter int unsigned  SCR_TAP_A   = 17,
   parameter int unsigned  SCR_TAP_B   = 22,
   parameter logic [3:0]   STEP_NORMAL = 4'h1,
   parameter logic [3:0]   STEP_FAST   = 4'h8
)
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // control channel and framing
   input  wire ltc_pkg::ltc_cbyte_t  cbyte_i,
   input  wire logic                 frame_pulse_i,
   // data path to and from the line coder
   input  wire ltc_pkg::ltc_bit_t    tx_bit_i,
   input  wire ltc_pkg::ltc_bit_t    rx_bit_i,
   output ltc_pkg::ltc_bit_t         tx_line_o,
   output ltc_pkg::ltc_bit_t         rx_data_o,
   // control outputs
   output ltc_pkg::ltc_fields_t      fields_o,
   output logic [7:0]                control_word_o,
   output logic [1:0]                default_mode_o,
   output logic [3:0]                sig_bits_o,
   output logic                      sig_in_bearer_slot_o,
   output logic [3:0]                converge_step_o,
   output logic                      tx_housekeeping_o,
   output logic                      diag_clear_o,
   output ltc_pkg::ltc_cbyte_t       diag_write_o
);
   import ltc_pkg::*;

   if (SCR_TAP_A >= SCR_W || SCR_TAP_B >= SCR_W || SCR_TAP_A == SCR_TAP_B)
   begin : g_bad_taps
      $error("scrambler taps must be distinct and inside the register");
   end

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync <= RST_SYNC_INIT[1:0];
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ****************************************
   // byte decode
   // ****************************************
   logic [1:0] sel;
   logic       wr_ctrl;
   logic       wr_diag;
   logic       is_default;
   logic [7:0] next_word;

   assign sel        = {cbyte_i.data[1], cbyte_i.data[0]};
   assign wr_ctrl    = cbyte_i.valid && (sel == SEL_CTRL);
   assign wr_diag    = cbyte_i.valid && (sel == SEL_DIAG);
   assign is_default = (cbyte_i.data & DEFAULT_MASK) == DEFAULT_MASK;

   always_comb
   begin
      next_word = cbyte_i.data;
      if (is_default)
      begin
         next_word = cbyte_i.data[BIT_RATE] ? DEFAULT2_WORD : DEFAULT1_WORD;
      end
   end

   // ****************************************
   // control word register
   // ****************************************
   logic [7:0] word;
   logic [1:0] defmode;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         word <= CW_RESET;
      else if (wr_ctrl)
         word <= next_word;
   end

   // remember which default is in force
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         defmode <= DEFMODE_NONE;
      else if (wr_ctrl)
         defmode <= !is_default ? DEFMODE_NONE
                  : (cbyte_i.data[BIT_RATE] ? DEFMODE_2 : DEFMODE_1);
   end

   // ****************************************
   // diagnostics clear and forwarding
   // ****************************************
   logic clear_pending;
   logic clear_req;

   // a hold bit of 0 arms a clear for the next frame pulse
   assign clear_req = wr_ctrl && !next_word[BIT_DIAG_HOLD];

   // a write in the frame-pulse cycle arms the following pulse, so it is never lost
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         clear_pending <= 1'b0;
      else if (clear_req)
         clear_pending <= 1'b1;
      else if (frame_pulse_i)
         clear_pending <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         diag_clear_o <= 1'b0;
      else
         diag_clear_o <= frame_pulse_i && clear_pending;
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         diag_write_o <= '0;
      else
         diag_write_o <= '{valid: wr_diag, data: cbyte_i.data};
   end

   // ****************************************
   // field decode
   // ****************************************
   assign fields_o.diag_clear_hold      = word[BIT_DIAG_HOLD];
   assign fields_o.line_rate_select     = word[BIT_RATE];
   assign fields_o.signalling_in_bearer = word[BIT_SIG_BEARER];
   assign fields_o.scrambler_enable     = word[BIT_SCRAMBLE];
   assign fields_o.fast_converge        = word[BIT_FAST];
   assign fields_o.tx_housekeeping      = word[BIT_HK];
   assign control_word_o                = word;
   assign default_mode_o                = defmode;
   assign tx_housekeeping_o             = word[BIT_HK];
   assign sig_in_bearer_slot_o          = word[BIT_SIG_BEARER];

   // all eight bits in bearer mode
   assign sig_bits_o = word[BIT_SIG_BEARER] ? SIG_BITS_ALL
                     : (word[BIT_RATE] ? SIG_BITS_160 : SIG_BITS_80);

   assign converge_step_o = word[BIT_FAST] ? STEP_FAST : STEP_NORMAL;

   // ****************************************
   // scrambler and descrambler
   // ****************************************
   // self-synchronising, so the far end recovers without a shared seed
   logic [SCR_W-1:0] tx_sr;
   logic [SCR_W-1:0] rx_sr;
   logic             tx_scr;
   logic             rx_dscr;

   assign tx_scr  = tx_bit_i.dat ^ tx_sr[SCR_TAP_A] ^ tx_sr[SCR_TAP_B];
   assign rx_dscr = rx_bit_i.dat ^ rx_sr[SCR_TAP_A] ^ rx_sr[SCR_TAP_B];

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         tx_sr <= '0;
      else if (tx_bit_i.valid && word[BIT_SCRAMBLE])
         tx_sr <= {tx_sr[SCR_W-2:0], tx_scr};
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rx_sr <= '0;
      else if (rx_bit_i.valid && word[BIT_SCRAMBLE])
         rx_sr <= {rx_sr[SCR_W-2:0], rx_bit_i.dat};
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_line_o <= '0;
         rx_data_o <= '0;
      end
      else
      begin
         tx_line_o <= '{valid: tx_bit_i.valid,
                        dat:   word[BIT_SCRAMBLE] ? tx_scr : tx_bit_i.dat};
         rx_data_o <= '{valid: rx_bit_i.valid,
                        dat:   word[BIT_SCRAMBLE] ? rx_dscr : rx_bit_i.dat};
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   property p_sel_ctrl;
      cbyte_i.valid && cbyte_i.data[1:0] == 2'h0 && !is_default
         |=> word == $past(cbyte_i.data);
   endproperty
   a_sel_ctrl: assert property (p_sel_ctrl) else $error("control byte not latched");

   property p_sel_diag;
      cbyte_i.valid && cbyte_i.data[0] == 1'b0 && cbyte_i.data[1] == 1'b1
         |=> diag_write_o.valid && $stable(word);
   endproperty
   a_sel_diag: assert property (p_sel_diag) else $error("diagnostics byte misrouted");

   property p_clear;
      cbyte_i.valid && cbyte_i.data[1:0] == 2'h0 && !cbyte_i.data[2] && !is_default
         ##1 !frame_pulse_i ##1 frame_pulse_i |=> diag_clear_o;
   endproperty
   a_clear: assert property (p_clear) else $error("diagnostics clear missed");

   property p_no_clear;
      !clear_pending |=> !diag_clear_o;
   endproperty
   a_no_clear: assert property (p_no_clear) else $error("spurious diagnostics clear");

   property p_sig_bits;
      sig_bits_o == (fields_o.signalling_in_bearer ? 4'h8
                    : (fields_o.line_rate_select ? 4'h2 : 4'h1));
   endproperty
   a_sig_bits: assert property (p_sig_bits) else $error("wrong signalling bit count");

   property p_bypass;
      tx_bit_i.valid && !word[5] |=> tx_line_o.dat == $past(tx_bit_i.dat);
   endproperty
   a_bypass: assert property (p_bypass) else $error("scrambler not bypassed");

   property p_step;
      converge_step_o == (word[6] ? STEP_FAST : STEP_NORMAL);
   endproperty
   a_step: assert property (p_step) else $error("wrong convergence speed");

   property p_def1;
      cbyte_i.valid && cbyte_i.data == 8'hF0 |=> word == 8'h00 && !tx_housekeeping_o;
   endproperty
   a_def1: assert property (p_def1) else $error("default mode 1 wrong");

   property p_def2;
      cbyte_i.valid && cbyte_i.data[1:0] == 2'h0 && cbyte_i.data[7:3] == 5'h1F
         |=> word == 8'h08 && default_mode_o == 2'h2 ##1 ($stable(word) || $past(wr_ctrl));
   endproperty
   a_def2: assert property (p_def2) else $error("default mode 2 wrong");

   property p_hold;
      !wr_ctrl |=> $stable(word);
   endproperty
   a_hold: assert property (p_hold) else $error("control word changed unprompted");

   c_def1:  cover property (wr_ctrl && is_default && !cbyte_i.data[3]);
   c_def2:  cover property (wr_ctrl && is_default && cbyte_i.data[3]);
   c_clear: cover property (diag_clear_o);
   c_scr:   cover property (tx_line_o.valid && word[5]);

endmodule : ltc_control_word

// *** verif/ltc_ctrl_host.sv ***
// system controller model: control channel bytes and frame pulses
`timescale 1ns/1ns
module ltc_ctrl_host
(
   // clock
   input  wire logic           clk_i,
   // control channel and framing
   output ltc_pkg::ltc_cbyte_t cbyte_o,
   output logic                frame_pulse_o
);
   import ltc_pkg::*;

   initial
   begin
      cbyte_o       = '0;
      frame_pulse_o = 1'b0;
   end

   task automatic send(input logic [7:0] b);
      @(posedge clk_i);
      cbyte_o <= '{valid: 1'b1, data: b};
      @(posedge clk_i);
      // idle bus shows the inverse so a stale byte cannot pass for a new one
      cbyte_o <= '{valid: 1'b0, data: ~b};
   endtask : send

   task automatic frame();
      @(posedge clk_i);
      frame_pulse_o <= 1'b1;
      @(posedge clk_i);
      frame_pulse_o <= 1'b0;
   endtask : frame
endmodule : ltc_ctrl_host

// *** verif/line_transceiver_control_word_tb.sv ***
// self-checking bench for the control word block
`timescale 1ns/1ns
module line_transceiver_control_word_tb;
   import ltc_pkg::*;

   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   ltc_cbyte_t  cbyte, diag_wr;
   logic        frame_pulse, bearer_slot, hk, diag_clear;
   ltc_bit_t    tx_bit = '0, rx_bit = '0, tx_line, rx_data;
   ltc_fields_t fields;
   logic [7:0]  cword;
   logic [1:0]  dmode;
   logic [3:0]  sig_bits, step;
   int          errors = 0, cmp_count = 0, seed = 68;
   logic [25:0] q_ctl[$], last_ctl;
   logic [7:0]  q_diag[$];
   logic        q_clr[$], q_tx[$], q_rx[$];
   logic        armed = 1'b0, took = 1'b0;
   // bench copy of the self-synchronising scrambler state
   logic [22:0] m_tx = '0, m_rx = '0;
   logic [7:0]  seq[8] = '{8'hA8, 8'h5A, 8'h3D, 8'hF0, 8'hF8, 8'h00, 8'h04, 8'h7F};
   wire  [25:0] got_ctl = {cword, dmode, sig_bits, step, hk, bearer_slot, fields};

   initial
      forever #10 clk_i = ~clk_i;

   ltc_ctrl_host ltc_ctrl_host_inst (.clk_i(clk_i), .cbyte_o(cbyte), .frame_pulse_o(frame_pulse));

   ltc_control_word ltc_control_word_inst
   (
      .clk_i               (clk_i),
      .resetn_i            (resetn_i),
      .cbyte_i             (cbyte),
      .frame_pulse_i       (frame_pulse),
      .tx_bit_i            (tx_bit),
      .rx_bit_i            (rx_bit),
      .tx_line_o           (tx_line),
      .rx_data_o           (rx_data),
      .fields_o            (fields),
      .control_word_o      (cword),
      .default_mode_o      (dmode),
      .sig_bits_o          (sig_bits),
      .sig_in_bearer_slot_o(bearer_slot),
      .converge_step_o     (step),
      .tx_housekeeping_o   (hk),
      .diag_clear_o        (diag_clear),
      .diag_write_o        (diag_wr)
   );

   // ****************************************
   // expectations and comparisons
   // ****************************************
   function automatic logic [25:0] exp_ctl(input logic [7:0] b);
      logic       dflt;
      logic [7:0] w;
      dflt = (b[7:4] == 4'hF);
      w    = dflt ? (b[3] ? 8'h08 : 8'h00) : b;
      return {w, dflt ? (b[3] ? 2'h2 : 2'h1) : 2'h0, w[4] ? 4'h8 : (w[3] ? 4'h2 : 4'h1),
              w[6] ? 4'h8 : 4'h1, w[7], w[4], w[7:2]};
   endfunction : exp_ctl

   task automatic note(input logic ok, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (!ok)
      begin
         errors++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : note

   task automatic chk_ctl(input logic [25:0] e, input logic [25:0] g);
      note(g === e, 32'(e), 32'(g));
   endtask : chk_ctl

   task automatic chk_diag(input logic [7:0] e, input logic [7:0] g);
      note(g === e, 32'(e), 32'(g));
   endtask : chk_diag

   task automatic chk_bit(input logic e, input logic g);
      note(g === e, 32'(e), 32'(g));
   endtask : chk_bit

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   always @(posedge clk_i)
      took <= cbyte.valid;

   // results are read mid-cycle, after the launching edge has settled
   always @(negedge clk_i)
   begin
      if (took)
         chk_ctl(q_ctl.pop_front(), got_ctl);
      if (diag_wr.valid)
         chk_diag(q_diag.size() ? q_diag.pop_front() : ~diag_wr.data, diag_wr.data);
      if (diag_clear)
         chk_bit(q_clr.size() ? q_clr.pop_front() : 1'b0, diag_clear);
      if (tx_line.valid)
         chk_bit(q_tx.size() ? q_tx.pop_front() : ~tx_line.dat, tx_line.dat);
      if (rx_data.valid)
         chk_bit(q_rx.size() ? q_rx.pop_front() : ~rx_data.dat, rx_data.dat);
   end

   // ****************************************
   // stimulus
   // ****************************************
   task automatic do_ctl(input logic [7:0] b);
      if (b[1:0] == 2'b00)
      begin
         last_ctl = exp_ctl(b);
         armed    = armed | ~last_ctl[20];
      end
      if (b[1:0] == 2'b10)
         q_diag.push_back(b);
      q_ctl.push_back(last_ctl);
      ltc_ctrl_host_inst.send(b);
   endtask : do_ctl

   task automatic do_frame();
      if (armed)
         q_clr.push_back(1'b1);
      armed = 1'b0;
      ltc_ctrl_host_inst.frame();
   endtask : do_frame

   task automatic do_bits(input int n, input logic scr);
      logic a;
      logic c;
      logic e;
      repeat (n)
      begin
         @(posedge clk_i);
         a = 1'($random(seed));
         c = 1'($random(seed));
         e = scr ? a ^ m_tx[17] ^ m_tx[22] : a;
         q_tx.push_back(e);
         q_rx.push_back(scr ? c ^ m_rx[17] ^ m_rx[22] : c);
         if (scr)
         begin
            m_tx = {m_tx[21:0], e};
            m_rx = {m_rx[21:0], c};
         end
         tx_bit <= '{valid: 1'b1, dat: a};
         rx_bit <= '{valid: 1'b1, dat: c};
      end
      @(posedge clk_i);
      tx_bit <= '0;
      rx_bit <= '0;
   endtask : do_bits

   initial
   begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      last_ctl = exp_ctl(8'h00);
      chk_ctl(last_ctl, got_ctl);
      do_ctl(8'h4C);
      repeat (240) do_frame();
      do_ctl(8'h44);
      repeat (480) do_frame();
      foreach (seq[i])
      begin
         do_ctl(seq[i]);
         do_frame();
      end
      repeat (40)
      begin
         do_ctl(8'($random(seed)));
         if ($random(seed) % 3 == 0)
            do_frame();
      end
      do_ctl(8'h84);
      do_bits(16, 1'b0);
      do_ctl(8'hA4);
      do_bits(32, 1'b1);
      repeat (4) @(posedge clk_i);
      if (q_ctl.size() + q_diag.size() + q_clr.size() + q_tx.size() + q_rx.size() != 0)
         note(1'b0, 32'h0, 32'h1);
      give_verdict();
   end

   initial
   begin
      #1000000;
      errors++;
      give_verdict();
   end
endmodule : line_transceiver_control_word_tb
